/* File: core/prs_rail_sequencer.sv */
/*
  Rail sequencer top: enable sources, delays, sleep, shutdown and modes.
  Assumes analog comparators and pins are asynchronous and are synchronised
  here; registers are reached over a plain strobe port on sys_clk.
*/
`timescale 1ns/1ps
module prs_rail_sequencer
  import prs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [CTLS-1:0] ctlPin,
  input wire logic [RAILS-1:0] railPg,
  input wire logic supplyAboveRise,
  input wire logic supplyAboveFall,
  input wire logic supplyAboveLower,
  input wire logic tempCrit,
  input wire logic tempBelowHyst,
  output logic [RAILS-1:0] railEn,
  output logic [RAILS-1:0] railSleep,
  output logic [RAILS-1:0] railStopSwitch,
  output logic [RAILS-1:0][CODE_W-1:0] railTarget,
  output logic railDischarge,
  output logic refEn,
  output logic ldo3v3En,
  output logic [PINS-1:0] statusPinOut,
  output logic [PINS-1:0] statusPinOe,
  output prs_mode_t modeOut
);
  localparam int SYNC_W = CTLS + RAILS + 5;
  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam int SD_W = $clog2(SD_DLY_CYC + 1);
  localparam logic [SD_W-1:0] SD_LAST = SD_W'(SD_DLY_CYC - 1);

  // 1-based select; zero selects nothing
  function automatic logic pick(input logic [15:0] v, input logic [3:0] s);
    return (s != 4'h0) && v[s - 4'h1];
  endfunction

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  always_ff @(posedge sys_clk)
  begin
    meta_r <= {ctlPin, railPg, supplyAboveRise, supplyAboveFall,
               supplyAboveLower, tempCrit, tempBelowHyst};
    sync_r <= meta_r;
  end
  wire logic [CTLS-1:0] ctlS = sync_r[SYNC_W-1 -: CTLS];
  wire logic [RAILS-1:0] pgS = sync_r[RAILS+4:5];
  wire logic riseS = sync_r[4];
  wire logic fallS = sync_r[3];
  wire logic lowerS = sync_r[2];
  wire logic critS = sync_r[1];
  wire logic coolS = sync_r[0];

  logic [TICK_W-1:0] tickCnt_r;
  logic tick_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tickCnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tickCnt_r == TICK_LAST);
      tickCnt_r <= (tickCnt_r == TICK_LAST) ? '0 : tickCnt_r + TICK_W'(1);
    end
  end

  prs_state_t state_r;
  prs_state_t stateNxt;
  prs_cause_t sdCause_r;
  prs_cause_t cause_r;
  logic [SD_W-1:0] sdCnt_r;
  logic dis_r;
  prs_rail_cfg_t cfg_r [RAILS];
  logic [RAILS-1:0] swEn_r;
  logic [RAILS-1:0] swOff_r;
  logic [PINS-1:0] pinSel_r;
  logic [PINS-1:0] pinLvl_r;
  logic [PINS-1:0] pinPp_r;
  logic [1:0] fltCfg_r;
  logic [1:0] slpCfg_r;
  logic [RAILS-1:0] railEnW;
  logic [RAILS-1:0] faultVec;
  logic ldWr;
  logic ldDone;
  logic [IDX_W-1:0] ldIdx;

  wire logic running = state_r == MD_RUN;
  wire logic holdRails = state_r == MD_SD_DLY;
  wire logic clrRails = !running && !holdRails;
  wire logic uvEv = running && !fallS;
  wire logic thEv = running && critS;
  wire logic flEv = running && (|faultVec);
  wire logic sdDone = holdRails && (sdCnt_r == SD_LAST);
  wire logic ldStart = (state_r != MD_LOAD) && (stateNxt == MD_LOAD);

  always_comb
  begin
    stateNxt = state_r;
    unique case (state_r)
      MD_OFF: if (riseS) stateNxt = MD_LOAD;
      MD_LOAD: if (ldDone) stateNxt = MD_RUN;
      MD_RUN:
      begin
        if (uvEv)
          stateNxt = MD_SD_DLY;
        else if (thEv || flEv)
          stateNxt = MD_SD_WAIT;
      end
      MD_SD_DLY: if (sdDone) stateNxt = MD_OFF;
      MD_SD_WAIT:
      begin
        if (sdCause_r.thermal)
        begin
          if (coolS) stateNxt = MD_LOAD;
        end
        else
          stateNxt = MD_LOAD;
      end
    endcase
  end

  wire logic disSet = (running && !uvEv && (thEv || flEv)) || sdDone;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r <= MD_OFF;
      sdCause_r <= '0;
      sdCnt_r <= '0;
      dis_r <= 1'b0;
    end
    else
    begin
      state_r <= stateNxt;
      sdCnt_r <= holdRails ? sdCnt_r + SD_W'(1) : '0;
      if (running)
        sdCause_r <= '{fault: !uvEv && !thEv, thermal: thEv && !uvEv,
                       uv: uvEv};
      if (disSet)
        dis_r <= 1'b1;
      else if (ldDone)
        dis_r <= 1'b0;
    end
  end

  prs_otp_loader #(.COUNT(RAILS)) u_loader (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(ldStart),
    .wrEn(ldWr),
    .idx(ldIdx),
    .done(ldDone)
  );

  wire logic idxOk = regAddr[3:0] < RAIL_CNT;
  wire logic [IDX_W-1:0] wIdx = regAddr[3:0];
  wire logic vcWr = regWr && (regAddr[7:4] == REG_VCODE_PAGE) && idxOk;
  wire logic scWr = regWr && (regAddr[7:4] == REG_SCODE_PAGE) && idxOk;
  wire logic [2:0] causeSet = {flEv && !uvEv && !thEv, thEv && !uvEv, uvEv};
  wire logic [2:0] causeClr = (regWr && regAddr == REG_SD_CAUSE) ?
                              regWdata[2:0] : 3'h0;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < RAILS; i++)
        cfg_r[i] <= '0;
    end
    else if (ldWr)
      cfg_r[ldIdx] <= prsOtpDefault(ldIdx);
    else if (vcWr)
      cfg_r[wIdx].vcode <= regWdata[CODE_W-1:0];
    else if (scWr)
    begin
      cfg_r[wIdx].scode <= regWdata[CODE_W-1:0];
      cfg_r[wIdx].decay <= regWdata[DECAY_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || ldWr)
    begin
      swEn_r <= '0;
      swOff_r <= '0;
      pinSel_r <= '0;
      pinLvl_r <= '0;
      pinPp_r <= '0;
      fltCfg_r <= '0;
      slpCfg_r <= '0;
    end
    else if (regWr)
    begin
      unique case (regAddr)
        REG_SW_EN_LO: swEn_r[7:0] <= regWdata;
        REG_SW_EN_HI: swEn_r[RAILS-1:8] <= regWdata[RAILS-9:0];
        REG_SW_OFF_LO: swOff_r[7:0] <= regWdata;
        REG_SW_OFF_HI: swOff_r[RAILS-1:8] <= regWdata[RAILS-9:0];
        REG_PIN_CTRL:
        begin
          pinSel_r <= regWdata[PINS-1:0];
          pinLvl_r <= regWdata[2*PINS-1:PINS];
        end
        REG_PIN_DRIVE: pinPp_r <= regWdata[PINS-1:0];
        REG_FAULT_CFG: fltCfg_r <= regWdata[1:0];
        REG_SLEEP_CFG: slpCfg_r <= regWdata[1:0];
        default: ;
      endcase
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cause_r <= '0;
    else
      cause_r <= (cause_r & ~causeClr) | causeSet;
  end

  // A pin used for sleep no longer acts as an enable
  wire logic sleep3 = slpCfg_r[SLP3_BIT] && !ctlS[CTL3_IDX];
  wire logic sleep6 = slpCfg_r[SLP6_BIT] && !ctlS[CTL6_IDX];
  wire logic [CTLS-1:0] slpMask = {slpCfg_r[SLP6_BIT], 2'h0,
                                   slpCfg_r[SLP3_BIT], 2'h0};
  wire logic [CTLS-1:0] ctlEff = ctlS & ~slpMask;

  for (genvar g = 0; g < RAILS; g++)
  begin : g_rail
    prs_rail_cfg_t c;
    logic pgSeen_r;
    logic [TMO_W-1:0] tmo_r;
    assign c = cfg_r[g];
    wire logic pinOk = (c.ctlSel == 3'h0) ||
                       pick({10'h000, ctlEff}, {1'b0, c.ctlSel});
    wire logic pgOk = (c.pgDep == 4'h0) || pick({4'h0, pgS}, c.pgDep);
    wire logic autoOn = ((c.ctlSel != 3'h0) || (c.pgDep != 4'h0)) &&
                        pinOk && pgOk;
    wire logic reqRun = running && !swOff_r[g] &&
                        (autoOn || swEn_r[g]);
    wire logic reqT = holdRails ? railEnW[g] : reqRun;
    wire logic slp = ((c.slpSel == SLP_CTL3) && sleep3) ||
                     ((c.slpSel == SLP_CTL6) && sleep6);
    wire logic decaying = slp && c.decay;

    prs_delay_timer #(.W(DLY_W)) u_dly (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clr(clrRails),
      .tick(tick_r),
      .req(reqT),
      .onDly(c.onDly),
      .offDly(c.offDly),
      .en(railEnW[g])
    );

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n || !railEnW[g])
      begin
        pgSeen_r <= 1'b0;
        tmo_r <= '0;
      end
      else
      begin
        if (pgS[g])
          pgSeen_r <= 1'b1;
        if (tick_r && !pgSeen_r && tmo_r != TMO_LIM)
          tmo_r <= tmo_r + TMO_W'(1);
      end
    end

    assign faultVec[g] = railEnW[g] &&
      ((fltCfg_r[FLT_LOSS_BIT] && pgSeen_r && !pgS[g] && !decaying) ||
       (fltCfg_r[FLT_TMO_BIT] && !pgSeen_r && tmo_r == TMO_LIM));

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        railSleep[g] <= 1'b0;
        railStopSwitch[g] <= 1'b0;
        railTarget[g] <= '0;
      end
      else
      begin
        railSleep[g] <= slp && railEnW[g];
        railStopSwitch[g] <= decaying && railEnW[g];
        railTarget[g] <= slp ? c.scode : c.vcode;
      end
    end
  end

  // Sleeping rails count as good so the tree does not drop
  wire logic pgAllow = running && fallS;
  wire logic [RAILS-1:0] pgTree = pgS | railSleep;
  logic [PINS-1:0] pinLvl;
  for (genvar p = 0; p < PINS; p++)
  begin : g_pin
    wire logic tree = pgAllow && (&(pgTree | ~prsTreeMask(2'(p))));
    assign pinLvl[p] = pinSel_r[p] ? pinLvl_r[p] : tree;
  end

  prs_mode_t modeNxt;
  always_comb
  begin
    unique case (state_r)
      MD_OFF: modeNxt = MODE_OFF;
      MD_LOAD: modeNxt = MODE_STANDBY;
      MD_RUN: modeNxt = (|railEnW) ? MODE_ACTIVE : MODE_STANDBY;
      default: modeNxt = MODE_SHUTDOWN;
    endcase
  end

  logic [7:0] rdNxt;
  always_comb
  begin
    rdNxt = 8'h00;
    if (regAddr[7:4] == REG_VCODE_PAGE && idxOk)
      rdNxt = {1'b0, cfg_r[wIdx].vcode};
    else if (regAddr[7:4] == REG_SCODE_PAGE && idxOk)
      rdNxt = {cfg_r[wIdx].decay, cfg_r[wIdx].scode};
    else
    begin
      unique case (regAddr)
        REG_SW_EN_LO: rdNxt = swEn_r[7:0];
        REG_SW_EN_HI: rdNxt = {4'h0, swEn_r[RAILS-1:8]};
        REG_SW_OFF_LO: rdNxt = swOff_r[7:0];
        REG_SW_OFF_HI: rdNxt = {4'h0, swOff_r[RAILS-1:8]};
        REG_PIN_CTRL: rdNxt = {pinLvl_r, pinSel_r};
        REG_PIN_DRIVE: rdNxt = {4'h0, pinPp_r};
        REG_FAULT_CFG: rdNxt = {6'h00, fltCfg_r};
        REG_SLEEP_CFG: rdNxt = {6'h00, slpCfg_r};
        REG_SD_CAUSE: rdNxt = {5'h00, cause_r};
        REG_MODE: rdNxt = {6'h00, modeOut};
        REG_PG_LO: rdNxt = pgS[7:0];
        REG_PG_HI: rdNxt = {4'h0, pgS[RAILS-1:8]};
        default: rdNxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      regRdata <= 8'h00;
      refEn <= 1'b0;
      ldo3v3En <= 1'b0;
      statusPinOut <= '0;
      statusPinOe <= '0;
      modeOut <= MODE_OFF;
      railDischarge <= 1'b0;
    end
    else
    begin
      regRdata <= regRd ? rdNxt : 8'h00;
      refEn <= lowerS;
      ldo3v3En <= lowerS;
      // Open drain only pulls low; push-pull drives both levels
      statusPinOut <= pinPp_r & pinLvl;
      statusPinOe <= pinPp_r | ~pinLvl;
      modeOut <= modeNxt;
      railDischarge <= dis_r;
    end
  end

  assign railEn = railEnW;
endmodule

/* File: core/prs_pkg.sv */
/*
  Shared constants, register offsets, carrier types and the one-time
  programmed default table of the rail sequencer.
  Assumes a single 200 MHz system clock; rail and pin counts are fixed here.
*/
package prs_pkg;
  localparam int RAILS = 12;
  localparam int CTLS = 6;
  localparam int PINS = 4;
  localparam int CLK_MHZ = 200;
  // Shutdown delay after the supply falls below the fall threshold, nominal, rounded down
  localparam int SD_DLY_NS = 444;
  localparam int SD_DLY_CYC = (SD_DLY_NS * CLK_MHZ) / 1000;
  // Delay tick of 1 ms drives the enable, disable and timeout counters
  localparam int TICK_US = 1000;
  localparam int TICK_CYC_DEF = TICK_US * CLK_MHZ;
  localparam int PG_TMO_MS = 10;
  localparam int PG_TMO_TICKS = (PG_TMO_MS * 1000) / TICK_US;
  localparam int DLY_W = 4;
  localparam int TMO_W = 4;
  localparam int IDX_W = 4;
  localparam int CODE_W = 7;
  // One extra tick because the first tick phase is unknown
  localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(PG_TMO_TICKS + 1);
  localparam logic [IDX_W-1:0] RAIL_CNT = IDX_W'(RAILS);
  localparam int CTL3_IDX = 2;
  localparam int CTL6_IDX = 5;
  localparam logic [1:0] SLP_NONE = 2'h0;
  localparam logic [1:0] SLP_CTL3 = 2'h1;
  localparam logic [1:0] SLP_CTL6 = 2'h2;

  localparam logic [7:0] REG_SW_EN_LO = 8'h00;
  localparam logic [7:0] REG_SW_EN_HI = 8'h01;
  localparam logic [7:0] REG_SW_OFF_LO = 8'h02;
  localparam logic [7:0] REG_SW_OFF_HI = 8'h03;
  localparam logic [7:0] REG_PIN_CTRL = 8'h04;
  localparam logic [7:0] REG_PIN_DRIVE = 8'h05;
  localparam logic [7:0] REG_FAULT_CFG = 8'h06;
  localparam logic [7:0] REG_SLEEP_CFG = 8'h07;
  localparam logic [7:0] REG_SD_CAUSE = 8'h08;
  localparam logic [7:0] REG_MODE = 8'h09;
  localparam logic [7:0] REG_PG_LO = 8'h0A;
  localparam logic [7:0] REG_PG_HI = 8'h0B;
  localparam logic [3:0] REG_VCODE_PAGE = 4'h1;
  localparam logic [3:0] REG_SCODE_PAGE = 4'h2;

  localparam int FLT_LOSS_BIT = 0;
  localparam int FLT_TMO_BIT = 1;
  localparam int SLP3_BIT = 0;
  localparam int SLP6_BIT = 1;
  localparam int DECAY_BIT = 7;

  typedef struct packed {
    logic [2:0] ctlSel;
    logic [3:0] pgDep;
    logic [DLY_W-1:0] onDly;
    logic [DLY_W-1:0] offDly;
    logic [1:0] slpSel;
    logic decay;
    logic [CODE_W-1:0] vcode;
    logic [CODE_W-1:0] scode;
  } prs_rail_cfg_t;

  typedef struct packed {
    logic fault;
    logic thermal;
    logic uv;
  } prs_cause_t;

  typedef enum logic [2:0] {MD_OFF, MD_LOAD, MD_RUN, MD_SD_DLY, MD_SD_WAIT}
    prs_state_t;
  typedef enum logic [1:0] {MODE_OFF, MODE_STANDBY, MODE_ACTIVE,
    MODE_SHUTDOWN} prs_mode_t;

  // Programmed defaults: rail i follows control input (i mod 6) + 1;
  // rail 0 may sleep on input 3 once that input is set up for sleep
  function automatic prs_rail_cfg_t prsOtpDefault(input logic [3:0] idx);
    prs_rail_cfg_t cfg;
    logic [3:0] grp;
    grp = idx % 4'h6;
    cfg = '0;
    cfg.ctlSel = grp[2:0] + 3'h1;
    cfg.slpSel = (idx == 4'h0) ? SLP_CTL3 : SLP_NONE;
    cfg.vcode = 7'h40;
    cfg.scode = 7'h20;
    return cfg;
  endfunction

  // Rails that form the power good tree of each status pin
  function automatic logic [RAILS-1:0] prsTreeMask(input logic [1:0] pin);
    logic [RAILS-1:0] m;
    m = '0;
    case (pin)
      2'h0: m = 12'h041;
      2'h1: m = 12'h082;
      2'h2: m = 12'h104;
      default: m = 12'h208;
    endcase
    return m;
  endfunction
endpackage

/* File: core/prs_delay_timer.sv */
/*
  Per-rail enable with independent turn-on and turn-off delays in ticks.
  Assumes tick is a one-cycle pulse on sys_clk and req is synchronous.
*/
`timescale 1ns/1ps
module prs_delay_timer
  import prs_pkg::*;
#(
  parameter int W = DLY_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic tick,
  input wire logic req,
  input wire logic [W-1:0] onDly,
  input wire logic [W-1:0] offDly,
  output logic en
);
  logic [W-1:0] cnt_r;
  logic en_r;
  wire logic [W-1:0] dlyNow = req ? onDly : offDly;
  wire logic pend = req != en_r;
  // Delay runs only while req differs from the current enable, in either direction
  wire logic expire = pend && (cnt_r >= dlyNow);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clr)
    begin
      en_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (!pend)
      cnt_r <= '0;
    else if (expire)
    begin
      en_r <= req;
      cnt_r <= '0;
    end
    else if (tick)
      cnt_r <= cnt_r + W'(1);
  end

  assign en = en_r;
endmodule

/* File: core/prs_otp_loader.sv */
/*
  Walks the programmed default table one entry per cycle.
  Assumes start is a one-cycle pulse; a start while busy is ignored.
*/
`timescale 1ns/1ps
module prs_otp_loader
  import prs_pkg::*;
#(
  parameter int COUNT = RAILS
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  output logic wrEn,
  output logic [IDX_W-1:0] idx,
  output logic done
);
  localparam logic [IDX_W-1:0] LAST = IDX_W'(COUNT - 1);
  logic busy_r;
  logic [IDX_W-1:0] idx_r;
  logic done_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      idx_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start && !busy_r)
      begin
        busy_r <= 1'b1;
        idx_r <= '0;
      end
      else if (busy_r)
      begin
        if (idx_r == LAST)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        else
          idx_r <= idx_r + IDX_W'(1);
      end
    end
  end

  assign wrEn = busy_r;
  assign idx = idx_r;
  assign done = done_r;
endmodule

/* File: tb/prs_host_model.sv */
/*
  Host and rail model: control pins and per-rail power good.
  Assumes the bench changes ctlReq and pgHold right after a clock edge.
*/
`timescale 1ns/1ps
module prs_host_model
  import prs_pkg::*;
#(
  parameter int PG_LAT = 5
)
(
  input wire logic sys_clk,
  input wire logic hostPwr,
  input wire logic [CTLS-1:0] ctlReq,
  input wire logic [RAILS-1:0] pgHold,
  input wire logic [RAILS-1:0] railEn,
  input wire logic [RAILS-1:0] railStop,
  output logic [CTLS-1:0] ctlPin,
  output logic [RAILS-1:0] railPg
);
  logic [RAILS-1:0] pgPipe_r [PG_LAT];
  // Host drives its control pins only once its own supply is up
  assign ctlPin = hostPwr ? ctlReq : '0;
  // A held rail never comes good, so the timeout path can be reached
  always_ff @(posedge sys_clk)
  begin
    // A rail that stops switching decays and loses its power good
    pgPipe_r[0] <= railEn & ~pgHold & ~railStop;
    for (int i = 1; i < PG_LAT; i++)
    begin
      pgPipe_r[i] <= pgPipe_r[i-1];
    end
  end
  assign railPg = pgPipe_r[PG_LAT-1] & railEn;
endmodule

/* File: tb/prs_seq_assertions.sv */
/*
  Port checker of the rail sequencer.
  Assumes binding into prs_rail_sequencer on its single sys_clk domain.
*/
`timescale 1ns/1ps
module prs_seq_assertions
  import prs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic supplyAboveFall,
  input wire logic tempCrit,
  input wire logic [RAILS-1:0] railEn,
  input wire logic [RAILS-1:0][CODE_W-1:0] railTarget,
  input wire logic railDischarge,
  input wire logic refEn,
  input wire logic ldo3v3En,
  input wire prs_mode_t modeOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_offRails;
    modeOut == MODE_OFF |-> railEn == '0;
  endproperty
  a_offRails: assert property (p_offRails) else $error("rail on in off");
  property p_refPair;
    refEn == ldo3v3En;
  endproperty
  a_refPair: assert property (p_refPair) else $error("ref and 3v3 split");
  // Rails must stay on for 80 cycles after the supply drops, short of the nominal delay
  property p_uvHold;
    $fell(supplyAboveFall) && railEn != '0 |-> ##80 railEn != '0;
  endproperty
  a_uvHold: assert property (p_uvHold) else $error("uv off too early");
  property p_uvOff;
    $fell(supplyAboveFall) && railEn != '0 |->
      ##[85:100] (railEn == '0 && railDischarge);
  endproperty
  a_uvOff: assert property (p_uvOff) else $error("uv off missing");
  property p_thermal;
    $rose(tempCrit) && railEn != '0 |-> ##[1:8] railEn == '0;
  endproperty
  a_thermal: assert property (p_thermal) else $error("hot rails stay");
  property p_disch;
    $rose(railDischarge) |-> ##[0:2] railEn == '0;
  endproperty
  a_disch: assert property (p_disch) else $error("discharge on live");
  property p_rdIdle;
    !regRd |=> regRdata == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data idle");
  property p_rdMode;
    regRd && regAddr == REG_MODE |=> regRdata == {6'h00, $past(modeOut)};
  endproperty
  a_rdMode: assert property (p_rdMode) else $error("mode read bad");
  property p_swOff;
    regWr && regAddr == REG_SW_OFF_LO && regWdata == 8'hFF |->
      ##[1:4] railEn[7:0] == 8'h00;
  endproperty
  a_swOff: assert property (p_swOff) else $error("force off ignored");
  property p_vcode;
    regWr && regAddr == 8'h11 && regWdata == 8'h55 |->
      ##[1:3] railTarget[1] == 7'h55;
  endproperty
  a_vcode: assert property (p_vcode) else $error("code write lost");
  property p_active;
    $rose(|railEn) |-> ##[0:2] modeOut == MODE_ACTIVE;
  endproperty
  a_active: assert property (p_active) else $error("not active");
  c_disch: cover property ($rose(railDischarge));
  c_active: cover property ($rose(modeOut == MODE_ACTIVE));
  c_hot: cover property ($rose(tempCrit) && railEn != '0);
endmodule
bind prs_rail_sequencer prs_seq_assertions #(.TICK_CYC(TICK_CYC))
  i_prs_seq_assertions (.sys_clk(sys_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .supplyAboveFall(supplyAboveFall),
  .tempCrit(tempCrit), .railEn(railEn), .railTarget(railTarget),
  .railDischarge(railDischarge), .refEn(refEn), .ldo3v3En(ldo3v3En),
  .modeOut(modeOut));

/* File: tb/tb_top.sv */
/*
  Self-checking bench of the rail sequencer: bus, pins, shutdown paths.
  Assumes 200 MHz and a delay tick shortened to 20 cycles.
*/
`timescale 1ns/1ps
module tb_top
  import prs_pkg::*;
;
  localparam int TCK = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic [CTLS-1:0] ctlReq = '0;
  logic [CTLS-1:0] ctlPin;
  logic [RAILS-1:0] pgHold = '0;
  logic [RAILS-1:0] railPg;
  logic supplyAboveRise = 1'b0;
  logic supplyAboveFall = 1'b0;
  logic supplyAboveLower = 1'b0;
  logic tempCrit = 1'b0;
  logic tempBelowHyst = 1'b1;
  logic [RAILS-1:0] railEn;
  logic [RAILS-1:0][CODE_W-1:0] railTarget;
  logic [RAILS-1:0] railSleep;
  logic [RAILS-1:0] railStopSwitch;
  logic [PINS-1:0] statusPinOut;
  logic [PINS-1:0] statusPinOe;
  logic railDischarge;
  logic refEn;
  logic ldo3v3En;
  prs_mode_t modeOut;
  int fails = 0;
  int checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  prs_host_model i_prs_host_model (.sys_clk(sys_clk),
    .hostPwr(supplyAboveLower), .ctlReq(ctlReq), .pgHold(pgHold),
    .railEn(railEn), .railStop(railStopSwitch), .ctlPin(ctlPin),
    .railPg(railPg));

  prs_rail_sequencer #(.TICK_CYC(TCK)) i_prs_rail_sequencer (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .ctlPin(ctlPin), .railPg(railPg),
    .supplyAboveRise(supplyAboveRise), .supplyAboveFall(supplyAboveFall),
    .supplyAboveLower(supplyAboveLower), .tempCrit(tempCrit),
    .tempBelowHyst(tempBelowHyst), .railEn(railEn),
    .railSleep(railSleep), .railStopSwitch(railStopSwitch),
    .railTarget(railTarget),
    .railDischarge(railDischarge), .refEn(refEn), .ldo3v3En(ldo3v3En),
    .statusPinOut(statusPinOut), .statusPinOe(statusPinOe),
    .modeOut(modeOut));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait; running out of cycles ends the run at once
  task automatic waitEn(input logic [RAILS-1:0] e, input int lim);
    int n;
    n = 0;
    while (railEn !== e && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk("railEn", 16'(e), 16'(railEn));
    if (n == lim && railEn !== e)
    begin
      test_done();
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic regRead(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk("regRdata", 16'(e), 16'(regRdata));
  endtask

  task automatic t_off();
    cyc(5);
    chk("railEn", 16'h0000, 16'(railEn));
    chk("mode", 16'(MODE_OFF), 16'(modeOut));
    @(posedge sys_clk);
    supplyAboveLower <= 1'b1;
    cyc(8);
    chk("refEn", 16'h0001, 16'(refEn));
    chk("ldo3v3En", 16'h0001, 16'(ldo3v3En));
    chk("mode", 16'(MODE_OFF), 16'(modeOut));
  endtask

  task automatic t_powerUp();
    @(posedge sys_clk);
    supplyAboveFall <= 1'b1;
    supplyAboveRise <= 1'b1;
    cyc(30);
    chk("mode", 16'(MODE_STANDBY), 16'(modeOut));
    regRead(REG_MODE, 8'h01);
    regRead(8'hFF, 8'h00);
    @(posedge sys_clk);
    ctlReq <= 6'h01;
    waitEn(12'h041, 20);
    cyc(3);
    chk("mode", 16'(MODE_ACTIVE), 16'(modeOut));
    @(posedge sys_clk);
    ctlReq <= 6'h3F;
    waitEn(12'hFFF, 20);
    @(posedge sys_clk);
    ctlReq <= 6'h3D;
    waitEn(12'hF7D, 20);
  endtask

  task automatic t_software();
    regWrite(REG_SW_EN_LO, 8'h82);
    waitEn(12'hFFF, 10);
    // Force-off must win over a standing software enable
    regWrite(REG_SW_OFF_LO, 8'hFF);
    waitEn(12'hF00, 10);
    regWrite(REG_SW_OFF_LO, 8'h00);
    waitEn(12'hFFF, 10);
    regWrite(REG_SW_EN_LO, 8'h00);
    waitEn(12'hF7D, 10);
    regWrite(8'h11, 8'h55);
    cyc(3);
    chk("target1", 16'h0055, 16'(railTarget[1]));
    chk("target0", 16'h0040, 16'(railTarget[0]));
  endtask

  task automatic t_sleep();
    regWrite(REG_SLEEP_CFG, 8'h01);
    waitEn(12'hE79, 10);
    @(posedge sys_clk);
    ctlReq <= 6'h39;
    cyc(4);
    chk("sleep", 16'h0001, 16'(railSleep));
    chk("target0", 16'h0020, 16'(railTarget[0]));
    chk("stop", 16'h0000, 16'(railStopSwitch));
    regWrite(8'h20, 8'hA0);
    cyc(12);
    chk("stop", 16'h0001, 16'(railStopSwitch));
    chk("pinOe", 16'h0000, 16'(statusPinOe[0]));
    regWrite(REG_PIN_DRIVE, 8'h01);
    regWrite(REG_PIN_CTRL, 8'h01);
    cyc(2);
    chk("pin0", 16'h0002, 16'({statusPinOe[0], statusPinOut[0]}));
    @(posedge sys_clk);
    ctlReq <= 6'h3D;
    regWrite(REG_SLEEP_CFG, 8'h00);
    waitEn(12'hF7D, 20);
  endtask

  task automatic t_undervolt();
    @(posedge sys_clk);
    supplyAboveFall <= 1'b0;
    supplyAboveRise <= 1'b0;
    cyc(60);
    chk("railEn", 16'h0F7D, 16'(railEn));
    waitEn(12'h000, 50);
    chk("discharge", 16'h0001, 16'(railDischarge));
    cyc(2);
    chk("mode", 16'(MODE_OFF), 16'(modeOut));
    regRead(REG_SD_CAUSE, 8'h01);
    regWrite(REG_SD_CAUSE, 8'h07);
    @(posedge sys_clk);
    supplyAboveFall <= 1'b1;
    supplyAboveRise <= 1'b1;
    waitEn(12'hF7D, 60);
    chk("discharge", 16'h0000, 16'(railDischarge));
    chk("target1", 16'h0040, 16'(railTarget[1]));
  endtask

  task automatic t_thermal();
    @(posedge sys_clk);
    tempCrit <= 1'b1;
    tempBelowHyst <= 1'b0;
    waitEn(12'h000, 8);
    chk("discharge", 16'h0001, 16'(railDischarge));
    @(posedge sys_clk);
    tempCrit <= 1'b0;
    cyc(30);
    chk("railEn", 16'h0000, 16'(railEn));
    @(posedge sys_clk);
    tempBelowHyst <= 1'b1;
    waitEn(12'hF7D, 60);
    regRead(REG_SD_CAUSE, 8'h02);
    regWrite(REG_SD_CAUSE, 8'h07);
  endtask

  task automatic t_fault();
    regWrite(REG_FAULT_CFG, 8'h02);
    @(posedge sys_clk);
    pgHold <= 12'h002;
    regWrite(REG_SW_EN_LO, 8'h02);
    waitEn(12'hF7F, 10);
    waitEn(12'h000, 12 * TCK + 60);
    chk("discharge", 16'h0001, 16'(railDischarge));
    // Reload clears the software enable, so rail 1 stays off
    waitEn(12'hF7D, 60);
    regRead(REG_SD_CAUSE, 8'h04);
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_off();
    t_powerUp();
    t_software();
    t_sleep();
    t_undervolt();
    t_thermal();
    t_fault();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    test_done();
  end
endmodule
